// File: src/vcom_uart_pkg.sv
// constants, register map and types of the virtual serial port bridge
package vcom_uart_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and baud figures
    localparam int          CLK_HZ       = 125000000;
    localparam int          BAUD_DEFAULT = 115200;
    localparam int          BAUD_MIN     = 9600;
    localparam int          BAUD_MAX     = 921600;
    localparam int          DIV_W        = 14;
    localparam logic [13:0] DIV_RESET    = 14'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [13:0] DIV_MIN      = 14'(CLK_HZ / BAUD_MAX);
    localparam logic [13:0] DIV_MAX      = 14'(CLK_HZ / BAUD_MIN);
    localparam int          DATA_BITS    = 8;
    localparam logic [2:0]  LAST_BIT     = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_DIVISOR = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;

    // ctrl fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_MSB = 1;

    // status fields
    localparam int ST_RX_FULL   = 0;
    localparam int ST_TX_BUSY   = 1;
    localparam int ST_ENABLE    = 2;
    localparam int ST_SOCKET    = 3;
    localparam int ST_HOLD_OFF  = 4;
    localparam int ST_FRAME_ERR = 5;
    localparam int ST_OVERRUN   = 6;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0]
    {
        HS_DISABLED = 2'h0,
        HS_RTS      = 2'h1,
        HS_CTS      = 2'h2,
        HS_RTSCTS   = 2'h3
    } handshake_t;

    localparam handshake_t MODE_RESET = HS_DISABLED;

    typedef enum { TX_IDLE, TX_START, TX_DATA, TX_STOP } tx_state_t;
    typedef enum { RX_IDLE, RX_START, RX_DATA, RX_STOP } rx_state_t;

endpackage

// File: src/vcom_uart_flow_bridge.sv
// board-side serial bridge to the target with selectable rts/cts flow control
// How it works
// - after reset: 115200 baud, 8 data bits, no parity, one stop, no handshake
// - the bit divisor is clamped to the span of 9600 to 921600 baud
// - with receive handshake on, clear-to-send drops while the receive buffer is full
// - with transmit handshake on, no new character starts once request-to-send drops
// - four modes: disabled, rts drives cts, cts honours rts, rtscts both
// - with transmit handshake off, request-to-send is ignored
// - no character starts in either direction while the interface enable is low; one already being transmitted finishes
// - a connected socket path locks the usb path out of both directions
//
// Added by the designer: the register offsets and the Wishbone slave port.
module vcom_uart_flow_bridge
    import vcom_uart_pkg::*;
#(
    parameter int AW = 8
)
(
    input  wire logic          clk,
    input  wire logic          resetn,
    // classic wishbone slave
    input  wire logic          wb_cyc,
    input  wire logic          wb_stb,
    input  wire logic          wb_we,
    input  wire logic [AW-1:0] wb_adr,
    input  wire logic [3:0]    wb_sel,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack,
    // target pins
    input  wire logic          target_txd,
    output logic               target_rxd,
    input  wire logic          target_rts_n,
    output logic               target_cts_n,
    output logic               target_cts_oe_n,
    input  wire logic          vcom_enable,
    // host paths
    input  wire logic          sock_connected,
    input  wire logic [7:0]    usb_in_data,
    input  wire logic          usb_in_valid,
    output logic               usb_in_ready,
    input  wire logic [7:0]    sock_in_data,
    input  wire logic          sock_in_valid,
    output logic               sock_in_ready,
    output logic      [7:0]    usb_out_data,
    output logic               usb_out_valid,
    input  wire logic          usb_out_ready,
    output logic      [7:0]    sock_out_data,
    output logic               sock_out_valid,
    input  wire logic          sock_out_ready
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] txd_sync_ff;
    logic [1:0] rts_sync_ff;
    logic [1:0] en_sync_ff;
    wire        rxd_s   = txd_sync_ff[1];
    wire        rts_n_s = rts_sync_ff[1];
    wire        en_s    = en_sync_ff[1];

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            txd_sync_ff <= 2'h3;
            rts_sync_ff <= 2'h3;
            en_sync_ff  <= 2'h0;
        end
        else
        begin
            txd_sync_ff <= {txd_sync_ff[0], target_txd};
            rts_sync_ff <= {rts_sync_ff[0], target_rts_n};
            en_sync_ff  <= {en_sync_ff[0], vcom_enable};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file
    handshake_t  mode_ff;
    logic [13:0] div_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic        frame_err_ff;
    logic        overrun_ff;
    logic        rx_full_ff;
    logic        tx_hold_ff;
    tx_state_t   tx_state_ff;

    wire        wb_req     = wb_cyc & wb_stb & ~ack_ff;
    wire        wb_wr      = wb_req & wb_we;
    wire        sel_ctrl   = (wb_adr[7:2] == ADDR_CTRL[7:2]);
    wire        sel_div    = (wb_adr[7:2] == ADDR_DIVISOR[7:2]);
    wire        sel_status = (wb_adr[7:2] == ADDR_STATUS[7:2]);
    wire [13:0] div_wr     = {wb_sel[1] ? wb_dat_i[13:8] : div_ff[13:8], wb_sel[0] ? wb_dat_i[7:0] : div_ff[7:0]};
    // out-of-range divisors are clamped so the link never leaves the supported baud span
    wire [13:0] div_clamp  = (div_wr < DIV_MIN) ? DIV_MIN : (div_wr > DIV_MAX) ? DIV_MAX : div_wr;
    wire        drive_cts  = (mode_ff == HS_RTS) | (mode_ff == HS_RTSCTS);
    wire        honour_rts = (mode_ff == HS_CTS) | (mode_ff == HS_RTSCTS);
    wire        hold_off   = honour_rts & rts_n_s;
    wire        clr_ferr   = wb_wr & sel_status & wb_sel[0] & wb_dat_i[ST_FRAME_ERR];
    wire        clr_ovr    = wb_wr & sel_status & wb_sel[0] & wb_dat_i[ST_OVERRUN];

    wire [31:0] status_word = {25'h0, overrun_ff, frame_err_ff, hold_off, sock_connected, en_s,
                               (tx_state_ff != TX_IDLE) | tx_hold_ff, rx_full_ff};
    wire [31:0] rd_mux = sel_ctrl   ? {30'h0, mode_ff} :
                         sel_div    ? {18'h0, div_ff} :
                         sel_status ? status_word : 32'h0;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            mode_ff  <= MODE_RESET;
            div_ff   <= DIV_RESET;
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0;
        end
        else
        begin
            ack_ff   <= wb_req;
            rdata_ff <= wb_req ? rd_mux : 32'h0;
            if (wb_wr & sel_ctrl & wb_sel[0])
                mode_ff <= handshake_t'(wb_dat_i[CTRL_MODE_MSB:CTRL_MODE_LSB]);
            if (wb_wr & sel_div & (wb_sel[1] | wb_sel[0]))
                div_ff <= div_clamp;
        end
    end

    assign wb_ack   = ack_ff;
    assign wb_dat_o = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // host to target: one holding byte, then the serialiser
    logic       usb_in_ready_ff;
    logic       sock_in_ready_ff;
    logic [7:0] tx_hold_data_ff;
    logic [7:0] tx_sh_ff;
    logic [13:0] tx_cnt_ff;
    logic [2:0] tx_bit_ff;
    logic       line_ff;

    wire usb_acc  = usb_in_valid & usb_in_ready_ff;
    wire sock_acc = sock_in_valid & sock_in_ready_ff;
    // the hold-off is only looked at between characters, so a byte in flight finishes
    wire tx_start = tx_hold_ff & (tx_state_ff == TX_IDLE) & en_s & ~hold_off;
    wire nxt_hold = usb_acc | sock_acc | (tx_hold_ff & ~tx_start);
    wire tx_bit_end = (tx_cnt_ff == div_ff - 14'h1);

    tx_state_t  nxt_tx_state;
    logic [7:0] nxt_tx_sh;
    logic [2:0] nxt_tx_bit;
    logic [13:0] nxt_tx_cnt;
    logic       nxt_line;

    always_comb
    begin
        nxt_tx_state = tx_state_ff;
        nxt_tx_sh    = tx_sh_ff;
        nxt_tx_bit   = tx_bit_ff;
        nxt_tx_cnt   = tx_bit_end ? 14'h0 : tx_cnt_ff + 14'h1;
        case (tx_state_ff)
            TX_IDLE:
            begin
                nxt_tx_cnt = 14'h0;
                if (tx_start)
                begin
                    nxt_tx_state = TX_START;
                    nxt_tx_sh    = tx_hold_data_ff;
                end
            end
            TX_START:
                if (tx_bit_end)
                begin
                    nxt_tx_state = TX_DATA;
                    nxt_tx_bit   = 3'h0;
                end
            TX_DATA:
                if (tx_bit_end)
                begin
                    nxt_tx_sh  = {1'b0, tx_sh_ff[7:1]};
                    nxt_tx_bit = tx_bit_ff + 3'h1;
                    if (tx_bit_ff == LAST_BIT)
                        nxt_tx_state = TX_STOP;
                end
            TX_STOP:
                if (tx_bit_end)
                    nxt_tx_state = TX_IDLE;
            default:
                nxt_tx_state = TX_IDLE;
        endcase
        nxt_line = (nxt_tx_state == TX_START) ? 1'b0 :
                   (nxt_tx_state == TX_DATA)  ? nxt_tx_sh[0] : 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            tx_state_ff      <= TX_IDLE;
            tx_sh_ff         <= 8'h00;
            tx_bit_ff        <= 3'h0;
            tx_cnt_ff        <= 14'h0;
            line_ff          <= 1'b1;
            tx_hold_ff       <= 1'b0;
            tx_hold_data_ff  <= 8'h00;
            usb_in_ready_ff  <= 1'b0;
            sock_in_ready_ff <= 1'b0;
        end
        else
        begin
            tx_state_ff      <= nxt_tx_state;
            tx_sh_ff         <= nxt_tx_sh;
            tx_bit_ff        <= nxt_tx_bit;
            tx_cnt_ff        <= nxt_tx_cnt;
            line_ff          <= nxt_line;
            tx_hold_ff       <= nxt_hold;
            tx_hold_data_ff  <= sock_acc ? sock_in_data : usb_acc ? usb_in_data : tx_hold_data_ff;
            usb_in_ready_ff  <= ~nxt_hold & ~sock_connected;
            sock_in_ready_ff <= ~nxt_hold & sock_connected;
        end
    end

    assign target_rxd    = line_ff;
    assign usb_in_ready  = usb_in_ready_ff;
    assign sock_in_ready = sock_in_ready_ff;

    ////////////////////////////////////////////////////////////////////////////
    // target to host: deserialiser into a one-byte receive buffer
    rx_state_t   rx_state_ff;
    logic [7:0]  rx_sh_ff;
    logic [2:0]  rx_bit_ff;
    logic [13:0] rx_cnt_ff;
    logic [7:0]  rx_buf_ff;
    logic        usb_out_valid_ff;
    logic        sock_out_valid_ff;
    logic        cts_n_ff;
    logic        cts_oe_n_ff;

    wire rx_half  = (rx_cnt_ff == {1'b0, div_ff[13:1]});
    wire rx_end   = (rx_cnt_ff == div_ff - 14'h1);
    wire rx_done  = (rx_state_ff == RX_STOP) & rx_end & rxd_s & en_s;
    wire rx_ferr  = (rx_state_ff == RX_STOP) & rx_end & ~rxd_s & en_s;
    wire take     = (usb_out_valid_ff & usb_out_ready) | (sock_out_valid_ff & sock_out_ready);
    // a new byte wins over a take in the same cycle
    wire nxt_full = rx_done | (rx_full_ff & ~take);

    rx_state_t   nxt_rx_state;
    logic [7:0]  nxt_rx_sh;
    logic [2:0]  nxt_rx_bit;
    logic [13:0] nxt_rx_cnt;

    always_comb
    begin
        nxt_rx_state = rx_state_ff;
        nxt_rx_sh    = rx_sh_ff;
        nxt_rx_bit   = rx_bit_ff;
        nxt_rx_cnt   = rx_cnt_ff + 14'h1;
        case (rx_state_ff)
            RX_IDLE:
            begin
                nxt_rx_cnt = 14'h0;
                if (en_s & ~rxd_s)
                    nxt_rx_state = RX_START;
            end
            RX_START:
                if (rx_half)
                begin
                    nxt_rx_cnt   = 14'h0;
                    nxt_rx_bit   = 3'h0;
                    nxt_rx_state = rxd_s ? RX_IDLE : RX_DATA;
                end
            RX_DATA:
                if (rx_end)
                begin
                    nxt_rx_cnt = 14'h0;
                    nxt_rx_sh  = {rxd_s, rx_sh_ff[7:1]};
                    nxt_rx_bit = rx_bit_ff + 3'h1;
                    if (rx_bit_ff == LAST_BIT)
                        nxt_rx_state = RX_STOP;
                end
            RX_STOP:
                if (rx_end)
                    nxt_rx_state = RX_IDLE;
            default:
                nxt_rx_state = RX_IDLE;
        endcase
        // dropping the enable abandons a character in flight
        if (!en_s)
            nxt_rx_state = RX_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rx_state_ff       <= RX_IDLE;
            rx_sh_ff          <= 8'h00;
            rx_bit_ff         <= 3'h0;
            rx_cnt_ff         <= 14'h0;
            rx_buf_ff         <= 8'h00;
            rx_full_ff        <= 1'b0;
            usb_out_valid_ff  <= 1'b0;
            sock_out_valid_ff <= 1'b0;
            cts_n_ff          <= 1'b1;
            cts_oe_n_ff       <= 1'b1;
            frame_err_ff      <= 1'b0;
            overrun_ff        <= 1'b0;
        end
        else
        begin
            rx_state_ff       <= nxt_rx_state;
            rx_sh_ff          <= nxt_rx_sh;
            rx_bit_ff         <= nxt_rx_bit;
            rx_cnt_ff         <= nxt_rx_cnt;
            rx_buf_ff         <= rx_done ? rx_sh_ff : rx_buf_ff;
            rx_full_ff        <= nxt_full;
            usb_out_valid_ff  <= nxt_full & ~sock_connected;
            sock_out_valid_ff <= nxt_full & sock_connected;
            cts_n_ff          <= nxt_full;
            cts_oe_n_ff       <= ~drive_cts;
            frame_err_ff      <= rx_ferr | (frame_err_ff & ~clr_ferr);
            overrun_ff        <= (rx_done & rx_full_ff & ~take) | (overrun_ff & ~clr_ovr);
        end
    end

    assign usb_out_data    = rx_buf_ff;
    assign sock_out_data   = rx_buf_ff;
    assign usb_out_valid   = usb_out_valid_ff;
    assign sock_out_valid  = sock_out_valid_ff;
    assign target_cts_n    = cts_n_ff;
    assign target_cts_oe_n = cts_oe_n_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_wb_req;
        wb_cyc & wb_stb & ~ack_ff;
    endsequence
    sequence s_ack_pulse;
        wb_ack ##1 ~wb_ack;
    endsequence

    property p_div_range;
        @(posedge clk) disable iff (!resetn) (div_ff >= DIV_MIN) && (div_ff <= DIV_MAX);
    endproperty
    a_div_range: assert property (p_div_range) else $error("divisor out of range");

    property p_cts_full;
        @(posedge clk) disable iff (!resetn) rx_full_ff |-> target_cts_n;
    endproperty
    a_cts_full: assert property (p_cts_full) else $error("cts asserted with full buffer");

    property p_cts_undriven;
        @(posedge clk) disable iff (!resetn) (mode_ff == HS_DISABLED) ##1 (mode_ff == HS_DISABLED) |-> target_cts_oe_n;
    endproperty
    a_cts_undriven: assert property (p_cts_undriven) else $error("cts driven in disabled mode");

    property p_hold_off;
        @(posedge clk) disable iff (!resetn) (tx_state_ff == TX_IDLE) && hold_off |=> (tx_state_ff == TX_IDLE);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("character started during hold-off");

    property p_ignore_rts;
        @(posedge clk) disable iff (!resetn)
            (tx_state_ff == TX_IDLE) && tx_hold_ff && en_s && !honour_rts |=> (tx_state_ff == TX_START) && !target_rxd;
    endproperty
    a_ignore_rts: assert property (p_ignore_rts) else $error("rts not ignored");

    property p_enable_gate;
        @(posedge clk) disable iff (!resetn)
            !en_s |=> (tx_state_ff != TX_START || $past(tx_state_ff) != TX_IDLE) && !rx_done;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("data moved while disabled");

    property p_usb_locked;
        @(posedge clk) disable iff (!resetn) sock_connected ##1 sock_connected |-> !usb_out_valid && !usb_in_ready;
    endproperty
    a_usb_locked: assert property (p_usb_locked) else $error("usb path active with socket");

    property p_frame_line;
        @(posedge clk) disable iff (!resetn)
            ((tx_state_ff == TX_START) |-> !target_rxd) and ((tx_state_ff inside {TX_IDLE, TX_STOP}) |-> target_rxd);
    endproperty
    a_frame_line: assert property (p_frame_line) else $error("bad start or stop level");

    property p_defaults;
        @(posedge clk) !resetn |=> (div_ff == DIV_RESET) && (mode_ff == HS_DISABLED) && target_cts_oe_n;
    endproperty
    a_defaults: assert property (p_defaults) else $error("wrong defaults after reset");

    property p_wb_ack;
        @(posedge clk) disable iff (!resetn) s_wb_req |=> s_ack_pulse;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("wishbone ack not a single cycle");

endmodule

// File: testbench/target_uart_model.sv
// behavioural target uart with optional rts/cts, 8n1 at a fixed bit length
module target_uart_model
#(
    parameter int DIV = 135
)
(
    input  wire logic clk,
    input  wire logic rxd,
    input  wire logic cts_line_n,
    input  wire logic hs_en,
    input  wire logic rts_hold,
    output logic      txd,
    output logic      rts_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rx_byte;
    int         rx_count;

    initial
    begin
        txd      = 1'b1;
        rx_byte  = 8'h00;
        rx_count = 0;
    end

    assign rts_n = rts_hold;

    // sends one character, waiting first while the board holds us off
    task automatic send(input logic [7:0] b, input logic stop_bit = 1'b1);
        while (hs_en && cts_line_n) @(posedge clk);
        txd <= 1'b0;
        repeat (DIV) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            txd <= b[i];
            repeat (DIV) @(posedge clk);
        end
        txd <= stop_bit;
        repeat (DIV) @(posedge clk);
        // a deliberately bad stop is followed by idle so the line does not stay low
        if (!stop_bit)
        begin
            txd <= 1'b1;
            repeat (DIV) @(posedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // receiver keeps taking characters whatever rts_n says
    always
    begin
        @(posedge clk);
        if (rxd === 1'b0)
        begin
            repeat (DIV / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (DIV) @(posedge clk);
                rx_byte[i] = rxd;
            end
            repeat (DIV) @(posedge clk);
            if (rxd === 1'b1)
                rx_count++;
        end
    end
endmodule

// File: testbench/vcom_uart_flow_bridge_tb_top.sv
// register, link and host path tests of the serial bridge
module vcom_uart_flow_bridge_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import vcom_uart_pkg::*;

`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

    localparam int DIV = int'(DIV_MIN);

    logic        clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]  wb_adr, usb_in_data, sock_in_data, usb_out_data, sock_out_data, got_usb, got_sock;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        target_txd, target_rxd, target_rts_n, target_cts_n, target_cts_oe_n, cts_line_n;
    logic        vcom_enable, sock_connected, usb_in_valid, usb_in_ready, sock_in_valid, sock_in_ready;
    logic        usb_out_valid, usb_out_ready, sock_out_valid, sock_out_ready, hs_en, rts_hold;
    int          err_count, n_tests, cycles, n_usb, n_sock, base;

    // an undriven cts line is shown as the inverse of its last value
    assign cts_line_n = target_cts_oe_n ? ~target_cts_n : target_cts_n;

    vcom_uart_flow_bridge vcom_uart_flow_bridge_i (.clk(clk), .resetn(resetn), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .target_txd(target_txd), .target_rxd(target_rxd),
        .target_rts_n(target_rts_n), .target_cts_n(target_cts_n), .target_cts_oe_n(target_cts_oe_n),
        .vcom_enable(vcom_enable), .sock_connected(sock_connected), .usb_in_data(usb_in_data),
        .usb_in_valid(usb_in_valid), .usb_in_ready(usb_in_ready), .sock_in_data(sock_in_data),
        .sock_in_valid(sock_in_valid), .sock_in_ready(sock_in_ready), .usb_out_data(usb_out_data),
        .usb_out_valid(usb_out_valid), .usb_out_ready(usb_out_ready), .sock_out_data(sock_out_data),
        .sock_out_valid(sock_out_valid), .sock_out_ready(sock_out_ready));

    target_uart_model #(.DIV(DIV)) target_uart_model_i (.clk(clk), .rxd(target_rxd),
        .cts_line_n(cts_line_n), .hs_en(hs_en), .rts_hold(rts_hold), .txd(target_txd), .rts_n(target_rts_n));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ceiling sized for about 44 characters at the shortest bit
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_count++;
            results();
        end
    end

    always @(posedge clk)
    begin
        if (usb_out_valid && usb_out_ready)
        begin
            got_usb <= usb_out_data;
            n_usb++;
        end
        if (sock_out_valid && sock_out_ready)
        begin
            got_sock <= sock_out_data;
            n_sock++;
        end
    end

    task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_dat_i <= d;
        wb_sel   <= 4'hF;
        do @(posedge clk); while (wb_ack !== 1'b1);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic host_send(input logic sock, input logic [7:0] b);
        if (sock)
        begin
            sock_in_data  <= b;
            sock_in_valid <= 1'b1;
            do @(posedge clk); while (sock_in_ready !== 1'b1);
            sock_in_valid <= 1'b0;
        end
        else
        begin
            usb_in_data  <= b;
            usb_in_valid <= 1'b1;
            do @(posedge clk); while (usb_in_ready !== 1'b1);
            usb_in_valid <= 1'b0;
        end
        // valid stays low for one edge so a following call never re-raises it in the same step
        @(posedge clk);
    endtask

    task automatic wait_rx(input logic [7:0] exp);
        base = target_uart_model_i.rx_count;
        repeat (14 * DIV) if (target_uart_model_i.rx_count == base) @(posedge clk);
        `CHECK(target_uart_model_i.rx_count != base, 1'b1)
        `CHECK(target_uart_model_i.rx_byte, exp)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_i} = '0;
        {usb_in_data, usb_in_valid, sock_in_data, sock_in_valid, sock_connected, hs_en, rts_hold} = '0;
        {err_count, n_tests, cycles, n_usb, n_sock} = '0;
        {got_usb, got_sock} = '0;
        usb_out_ready  = 1'b1;
        sock_out_ready = 1'b1;
        vcom_enable    = 1'b1;
        resetn         = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        `CHECK(target_cts_oe_n, 1'b1)
        `CHECK(target_rxd, 1'b1)
        wb_cycle(1'b0, ADDR_CTRL, 32'h0);
        `CHECK(rd, 32'h0)
        wb_cycle(1'b0, ADDR_DIVISOR, 32'h0);
        `CHECK(rd, 32'(DIV_RESET))
        wb_cycle(1'b0, 8'h0C, 32'h0);
        `CHECK(rd, 32'h0)
        wb_cycle(1'b1, ADDR_DIVISOR, 32'h1);
        wb_cycle(1'b0, ADDR_DIVISOR, 32'h0);
        `CHECK(rd, 32'(DIV_MIN))
        wb_cycle(1'b1, ADDR_DIVISOR, 32'h3FFF);
        wb_cycle(1'b0, ADDR_DIVISOR, 32'h0);
        `CHECK(rd, 32'(DIV_MAX))
        wb_cycle(1'b1, ADDR_DIVISOR, 32'(DIV_MIN));
        $display("test registers done");

        // mode disabled: rts held off is ignored, back-to-back bytes
        rts_hold <= 1'b1;
        host_send(1'b0, 8'hA5);
        host_send(1'b0, 8'h3C);
        wait_rx(8'hA5);
        wait_rx(8'h3C);
        $display("test ignore rts done");

        // mode cts: held byte waits, a byte in flight completes
        wb_cycle(1'b1, ADDR_CTRL, 32'(HS_CTS));
        `CHECK(target_cts_oe_n, 1'b1)
        host_send(1'b0, 8'h5A);
        repeat (3 * DIV) @(posedge clk);
        `CHECK(target_rxd, 1'b1)
        rts_hold <= 1'b0;
        wait_rx(8'h5A);
        host_send(1'b0, 8'hC3);
        repeat (3 * DIV) @(posedge clk);
        rts_hold <= 1'b1;
        wait_rx(8'hC3);
        rts_hold <= 1'b0;
        $display("test honour rts done");

        // mode rts: a full buffer raises cts to the target
        wb_cycle(1'b1, ADDR_CTRL, 32'(HS_RTS));
        `CHECK(target_cts_oe_n, 1'b0)
        hs_en         <= 1'b1;
        usb_out_ready <= 1'b0;
        target_uart_model_i.send(8'h96);
        repeat (DIV) @(posedge clk);
        `CHECK(target_cts_n, 1'b1)
        `CHECK(usb_out_data, 8'h96)
        usb_out_ready <= 1'b1;
        repeat (4) @(posedge clk);
        `CHECK(got_usb, 8'h96)
        `CHECK(target_cts_n, 1'b0)
        hs_en <= 1'b0;
        $display("test drive cts done");

        // mode rtscts: cts driven and a held-off target shows in status
        wb_cycle(1'b1, ADDR_CTRL, 32'(HS_RTSCTS));
        rts_hold <= 1'b1;
        repeat (3) @(posedge clk);
        wb_cycle(1'b0, ADDR_STATUS, 32'h0);
        `CHECK(rd, 32'h14)
        `CHECK(target_cts_oe_n, 1'b0)
        rts_hold <= 1'b0;
        $display("test both handshakes done");

        // enable low holds the byte back until enable returns
        wb_cycle(1'b1, ADDR_CTRL, 32'(HS_DISABLED));
        vcom_enable <= 1'b0;
        repeat (4) @(posedge clk);
        base = target_uart_model_i.rx_count;
        host_send(1'b0, 8'h11);
        repeat (12 * DIV) @(posedge clk);
        `CHECK(target_uart_model_i.rx_count, base)
        vcom_enable <= 1'b1;
        wait_rx(8'h11);
        $display("test enable done");

        // a connected socket owns both directions
        sock_connected <= 1'b1;
        repeat (3) @(posedge clk);
        `CHECK(usb_in_ready, 1'b0)
        host_send(1'b1, 8'h77);
        wait_rx(8'h77);
        base = n_usb;
        target_uart_model_i.send(8'hE1);
        repeat (DIV) @(posedge clk);
        `CHECK(got_sock, 8'hE1)
        `CHECK(n_usb, base)
        $display("test socket priority done");

        // a low stop bit drops the byte and sets the sticky frame error
        base = n_sock;
        target_uart_model_i.send(8'h5F, 1'b0);
        wb_cycle(1'b0, ADDR_STATUS, 32'h0);
        `CHECK(rd, 32'h2C)
        `CHECK(n_sock, base)
        wb_cycle(1'b1, ADDR_STATUS, 32'h20);
        wb_cycle(1'b0, ADDR_STATUS, 32'h0);
        `CHECK(rd, 32'h0C)
        $display("test frame error done");
        results();
    end
endmodule
